// [design/pwm_out_pkg.sv]
// Package for the PWM output stage: register offsets, widths, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package pwm_out_pkg;
    localparam int          NUM_GEN        = 4;
    localparam int          NUM_OUT        = 8;
    localparam int          CNT_W          = 16;
    localparam logic [11:0] OFS_CTRL       = 12'h000; // Enables, invert, fault select, drive level
    localparam logic [11:0] OFS_SYNC       = 12'h004; // RW: W [3:0] time base sync, W [7:4] update sync, R [7:4] pending
    localparam logic [11:0] OFS_FAULT      = 12'h008; // R: fault inputs, live
    localparam logic [11:0] OFS_IRQ_STAT   = 12'h00C; // R: sticky status
    localparam logic [11:0] OFS_IRQ_CLR    = 12'h010; // W: clear
    localparam logic [11:0] OFS_IRQ_EN     = 12'h014; // RW: enable
    localparam logic [11:0] OFS_PERIOD0    = 12'h020; // Period of generator n at +4*n
    localparam logic [11:0] OFS_WIDTH0     = 12'h040; // Width of output n at +4*n
    localparam logic [11:0] OFS_ACTIVE0    = 12'h060; // R: width in effect, output n at +4*n
    localparam int          CTRL_EN_LSB    = 0;
    localparam int          CTRL_INV_LSB   = 8;
    localparam int          CTRL_SUP_LSB   = 16;
    localparam int          CTRL_HIGH_LSB  = 24;
    localparam int          IRQ_GEN_LSB    = 0;  // generator_zero_irq_bit
    localparam int          IRQ_FAULT_LSB  = 4;  // fault input rising edge irq bit
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] WIDTH_RST  = 16'h0000;
endpackage : pwm_out_pkg

// [design/pwm_output_fault_sync.sv]
// PWM output stage with fault suppression and synchronised updates.
// Assumes APB on pclk; fault inputs synchronous to pclk; one tick per pclk.
//
// Contract
// - Interrupt status holds one bit per generator and per fault input.
// - Suppress-selected outputs go to their fault drive level, ignoring invert, during fault; others keep waveform.
// - Suppressed output defaults low unless drive-high is configured.
// - Per-output drive-high select forces a suppressed output high in fault.
// - Drive level ignored when suppress select is clear.
// - Per-output invert makes the output active low.
// - Disabled outputs are held inactive, except when suppressed during fault.
// - Per-output compare gives high width in PWM clock ticks.
// - Width readback returns the latest programmed value.
// - Later write overwrites the pending value before update.
// - Time base sync resets selected generator counters together.
// - Update sync applies queued values at next counter zero.
// - Period plus one is ticks between successive counter-zero pulses.
//
//------------------------------------------------------------
// Register map
//------------------------------------------------------------
// 0x000 control word, one byte per per-output select:
//       [7:0]   output_enable_select
//       [15:8]  output_invert_select
//       [23:16] fault_suppress_select
//       [31:24] fault_level_high_select
// 0x004 sync word
//       write [3:0] time base reset, one bit per generator
//       write [7:4] update request, one bit per generator
//       read  [7:4] update requests still waiting for zero
// 0x008 fault inputs as they stand, read only
// 0x00C interrupt status, sticky, read only
//       [3:0] generator counter reached zero
//       [7:4] fault input rising edge
// 0x010 interrupt clear, write one to clear
// 0x014 interrupt enable, same layout as status
// 0x020 + 4*g  programmed period of generator g
// 0x040 + 4*n  programmed width of output n
// 0x060 + 4*n  width in effect for output n, read only
//
//------------------------------------------------------------
// Timing
//------------------------------------------------------------
// Bus: pready is high from the first edge after reset, so
// every transfer ends at its first access edge. Read data is
// fetched in the setup cycle and registered at the setup edge,
// so it stands through the access cycle and is taken at the
// edge that completes the transfer. It drops to zero after.
// Unmapped reads flag pslverr in the same access cycle.
// Writes to read-only or unmapped offsets are dropped quietly.
//
// Counters: each generator counts 0..period and wraps, so the
// spacing of two zero pulses is period plus one clock.
// Output n follows generator n/2 and is high while the count
// is below its width in effect.
//
// Updates: period and width writes only queue a value. Nothing
// moves to the comparators until software requests an update
// for that generator; the move then happens at its next zero.
// A queued value can be overwritten any number of times; only
// the last one is ever applied. Trade-off: a generator left at
// the reset period waits a full 16-bit wrap for its update,
// unless a time base reset is issued with the request.
//
// Faults: any fault input high suppresses every selected
// output. The override sits behind enable and invert, so the
// pin shows the chosen level whatever the polarity setting.
// Pins lag the counter by one clock, being registered.
//------------------------------------------------------------
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_fault_sync
    import pwm_out_pkg::*;
(
    // APB slave
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Fault inputs, active high
    input  wire logic [pwm_out_pkg::NUM_GEN-1:0] fault_in,
    // Pins and interrupt
    output logic      [pwm_out_pkg::NUM_OUT-1:0] pwm_out,
    output logic                           irq
);
    import pwm_out_pkg::*;

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    logic [7:0]       output_enable_select_q, output_enable_select_d;
    logic [7:0]       output_invert_select_q, output_invert_select_d;
    logic [7:0]       fault_suppress_select_q, fault_suppress_select_d;
    logic [7:0]       fault_level_high_select_q, fault_level_high_select_d;
    logic [CNT_W-1:0] per_prog_q [NUM_GEN], per_prog_d [NUM_GEN];
    logic [CNT_W-1:0] per_act_q  [NUM_GEN], per_act_d  [NUM_GEN];
    logic [CNT_W-1:0] wid_prog_q [NUM_OUT], wid_prog_d [NUM_OUT];
    logic [CNT_W-1:0] wid_act_q  [NUM_OUT], wid_act_d  [NUM_OUT];
    logic [CNT_W-1:0] cnt_q      [NUM_GEN], cnt_d      [NUM_GEN];
    logic [3:0]       upd_pend_q, upd_pend_d;
    logic [7:0]       irq_stat_q, irq_stat_d;
    logic [7:0]       irq_en_q, irq_en_d;
    logic [3:0]       fault_prev_q, fault_prev_d;
    logic [7:0]       pwm_out_d;
    logic             irq_d;
    logic [31:0]      prdata_d;
    logic             pslverr_d;

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    logic        wr_en, rd_en;
    logic [3:0]  zero_evt;
    logic [3:0]  fault_rise;
    logic        fault_any;
    logic [2:0]  widx;
    logic [1:0]  gidx;
    logic        hit_per, hit_wid, hit_act;
    logic [7:0]  raw_wave;

    // Single-cycle access phase: pready is high from the first edge after reset
    assign wr_en   = psel & penable & pwrite;
    // Reads fetched in setup so the data stands at the completing edge
    assign rd_en   = psel & ~penable & ~pwrite;
    assign gidx    = paddr[3:2];
    assign widx    = paddr[4:2];
    assign hit_per = (paddr[11:4] == OFS_PERIOD0[11:4]);
    assign hit_wid = (paddr[11:5] == OFS_WIDTH0[11:5]);
    assign hit_act = (paddr[11:5] == OFS_ACTIVE0[11:5]);
    assign fault_any = |fault_in;

    //------------------------------------------------------------
    // Registers, counters and update logic
    //------------------------------------------------------------
    always_comb begin
        output_enable_select_d    = output_enable_select_q;
        output_invert_select_d    = output_invert_select_q;
        fault_suppress_select_d   = fault_suppress_select_q;
        fault_level_high_select_d = fault_level_high_select_q;
        per_prog_d = per_prog_q;
        per_act_d  = per_act_q;
        wid_prog_d = wid_prog_q;
        wid_act_d  = wid_act_q;
        upd_pend_d = upd_pend_q;
        irq_en_d   = irq_en_q;
        fault_prev_d = fault_in;
        fault_rise   = fault_in & ~fault_prev_q;
        // Counters: count 0..period and wrap, so period + 1 = ticks between zeros
        for (int g = 0; g < NUM_GEN; g++) begin
            zero_evt[g] = (cnt_q[g] == '0);
            cnt_d[g] = (cnt_q[g] >= per_act_q[g]) ? '0 : cnt_q[g] + 16'h0001;
        end
        // Queued values reach the comparators only at counter zero
        for (int g = 0; g < NUM_GEN; g++) begin
            if (upd_pend_q[g] && zero_evt[g]) begin
                per_act_d[g]       = per_prog_q[g];
                wid_act_d[2*g]     = wid_prog_q[2*g];
                wid_act_d[2*g+1]   = wid_prog_q[2*g+1];
                upd_pend_d[g]      = 1'b0;
            end
        end
        if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    output_enable_select_d    = pwdata[CTRL_EN_LSB +: 8];
                    output_invert_select_d    = pwdata[CTRL_INV_LSB +: 8];
                    fault_suppress_select_d   = pwdata[CTRL_SUP_LSB +: 8];
                    fault_level_high_select_d = pwdata[CTRL_HIGH_LSB +: 8];
                end
                OFS_SYNC: begin
                    for (int g = 0; g < NUM_GEN; g++) begin
                        if (pwdata[g]) cnt_d[g] = '0;
                    end
                    upd_pend_d = upd_pend_d | pwdata[7:4];
                end
                OFS_IRQ_EN: irq_en_d = pwdata[7:0];
                default: begin
                    // Newest write wins; pending value simply overwritten
                    if (hit_per)
                        per_prog_d[gidx] = pwdata[CNT_W-1:0];
                    else if (hit_wid)
                        wid_prog_d[widx] = pwdata[CNT_W-1:0];
                end
            endcase
        end
        // Sticky status; a new event wins over a same-cycle clear
        irq_stat_d = irq_stat_q;
        if (wr_en && paddr == OFS_IRQ_CLR) irq_stat_d = irq_stat_d & ~pwdata[7:0];
        irq_stat_d[IRQ_GEN_LSB +: 4]   = irq_stat_d[IRQ_GEN_LSB +: 4] | zero_evt;
        irq_stat_d[IRQ_FAULT_LSB +: 4] = irq_stat_d[IRQ_FAULT_LSB +: 4] | fault_rise;
        irq_d = |(irq_stat_d & irq_en_d);
    end

    //------------------------------------------------------------
    // Output stage: compare, enable, invert, then fault override
    //------------------------------------------------------------
    always_comb begin
        for (int o = 0; o < NUM_OUT; o++) begin
            raw_wave[o] = (cnt_q[o/2] < wid_act_q[o]);
            pwm_out_d[o] = raw_wave[o] & output_enable_select_q[o];
            pwm_out_d[o] = pwm_out_d[o] ^ output_invert_select_q[o];
            // Fault last so the pin level ignores inversion
            if (fault_any && fault_suppress_select_q[o])
                pwm_out_d[o] = fault_level_high_select_q[o];
        end
    end

    //------------------------------------------------------------
    // Read mux
    //------------------------------------------------------------
    always_comb begin
        prdata_d  = '0;
        pslverr_d = 1'b0;
        if (rd_en) begin
            case (paddr)
                OFS_CTRL:     prdata_d = {fault_level_high_select_q, fault_suppress_select_q,
                                          output_invert_select_q, output_enable_select_q};
                OFS_SYNC:     prdata_d = {24'h000000, upd_pend_q, 4'h0};
                OFS_FAULT:    prdata_d = {28'h0000000, fault_in};
                OFS_IRQ_STAT: prdata_d = {24'h000000, irq_stat_q};
                OFS_IRQ_CLR:  prdata_d = '0;
                OFS_IRQ_EN:   prdata_d = {24'h000000, irq_en_q};
                default: begin
                    if (hit_per)      prdata_d = {16'h0000, per_prog_q[gidx]};
                    else if (hit_wid) prdata_d = {16'h0000, wid_prog_q[widx]};
                    else if (hit_act) prdata_d = {16'h0000, wid_act_q[widx]};
                    else              pslverr_d = 1'b1;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Flops
    //------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_enable_select_q    <= '0;
            output_invert_select_q    <= '0;
            fault_suppress_select_q   <= '0;
            fault_level_high_select_q <= '0;
            for (int g = 0; g < NUM_GEN; g++) begin
                per_prog_q[g] <= PERIOD_RST;
                per_act_q[g]  <= PERIOD_RST;
                cnt_q[g]      <= '0;
            end
            for (int o = 0; o < NUM_OUT; o++) begin
                wid_prog_q[o] <= WIDTH_RST;
                wid_act_q[o]  <= WIDTH_RST;
            end
            upd_pend_q   <= '0;
            irq_stat_q   <= '0;
            irq_en_q     <= '0;
            fault_prev_q <= '0;
            pwm_out      <= '0;
            irq          <= 1'b0;
            prdata       <= '0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else begin
            output_enable_select_q    <= output_enable_select_d;
            output_invert_select_q    <= output_invert_select_d;
            fault_suppress_select_q   <= fault_suppress_select_d;
            fault_level_high_select_q <= fault_level_high_select_d;
            per_prog_q   <= per_prog_d;
            per_act_q    <= per_act_d;
            wid_prog_q   <= wid_prog_d;
            wid_act_q    <= wid_act_d;
            cnt_q        <= cnt_d;
            upd_pend_q   <= upd_pend_d;
            irq_stat_q   <= irq_stat_d;
            irq_en_q     <= irq_en_d;
            fault_prev_q <= fault_prev_d;
            pwm_out      <= pwm_out_d;
            irq          <= irq_d;
            prdata       <= prdata_d;
            pready       <= 1'b1; // Zero wait states
            pslverr      <= pslverr_d;
        end
    end
endmodule // pwm_output_fault_sync
`default_nettype wire

// [dv/pwm_out_checker_assertions.sv]
// Checker for the PWM output stage: bus answers, fault levels, pins.
// Assumes binding to pwm_output_fault_sync; pins lag their cause by two clocks at most.
`timescale 1ns/1ps
`default_nettype none
module pwm_out_checker
    import pwm_out_pkg::*;
(
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic [pwm_out_pkg::NUM_GEN-1:0] fault_in,
    input wire logic [pwm_out_pkg::NUM_OUT-1:0] pwm_out,
    input wire logic        irq
);
    logic        rd_acc, rd_set, wr_acc, ctrl_wr, en_off;
    logic [31:0] ctrl_q;
    // Access decode
    assign rd_acc  = psel && penable && !pwrite;
    assign rd_set  = psel && !penable && !pwrite;
    assign wr_acc  = psel && penable && pwrite;
    assign ctrl_wr = wr_acc && paddr == OFS_CTRL;
    assign en_off  = wr_acc && paddr == OFS_IRQ_EN && pwdata[7:0] == 8'h00;
    // Shadow control word, so pin checks know the setup without peeking inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_q <= 32'h0;
        else if (ctrl_wr) ctrl_q <= pwdata;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_on_a: assert property ($past(presetn) |-> pready) else $error("pready low");
    rdata_idle_a: assert property (!$past(rd_set) |-> prdata == 32'h0 && !pslverr) else $error("stale read data");
    err_unmapped_a: assert property (rd_acc && paddr >= 12'h080 |-> pslverr) else $error("no error");
    width_upper_a: assert property (rd_acc && paddr[11:6] == 6'h01 |-> prdata[31:16] == 16'h0) else $error("wide");
    irq_masked_a: assert property (en_off |-> ##[1:2] !irq) else $error("irq not masked");
    supp_low_a: assert property ((|fault_in && !ctrl_wr)[*4] |-> (pwm_out & ctrl_q[23:16] & ~ctrl_q[31:24]) == 8'h0)
        else $error("suppressed pin high");
    supp_high_a: assert property ((|fault_in && !ctrl_wr)[*4] |-> (~pwm_out & ctrl_q[23:16] & ctrl_q[31:24]) == 8'h0)
        else $error("fault level pin low");
    off_idle_a: assert property ((!(|fault_in) && !ctrl_wr)[*4] |-> ((pwm_out ^ ctrl_q[15:8]) & ~ctrl_q[7:0]) == 8'h0)
        else $error("disabled pin active");
    unsup_idle_a: assert property ((!ctrl_wr)[*4] |-> ((pwm_out ^ ctrl_q[15:8]) & ~ctrl_q[7:0] & ~ctrl_q[23:16]) == 8'h0)
        else $error("fault moved pin");
    cover property (rd_acc);
    cover property ((|fault_in)[*4]);
    cover property ($rose(irq));
endmodule // pwm_out_checker
bind pwm_output_fault_sync pwm_out_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

// [dv/pwm_load.sv]
// Load on the PWM pins: counts high ticks per pin.
// Assumes pins sampled on pclk; clr restarts every count.
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
    // Clock and control
    input  wire logic       pclk,
    input  wire logic       clr,
    // Pins and counts
    input  wire logic [7:0] pins,
    output logic      [7:0] high_cnt [8]
);
    // A load only integrates; it never drives back
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 8; i++) high_cnt[i] <= clr ? 8'h00 : high_cnt[i] + 8'(pins[i]);
    end
endmodule // pwm_load
`default_nettype wire

// [dv/pwm_output_fault_sync_tb_top.sv]
// Testbench for the PWM output stage: APB master, fault drive, pin load.
// Assumes the package, checker and pwm_load are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_fault_sync_tb_top;
    import pwm_out_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic        pready, pslverr, irq, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0]  fault_in = 4'h0;
    logic [7:0]  pwm_out;
    logic [7:0]  high_cnt [8];
    int          bad_count = 0, n_compared = 0, diff;
    always #25 pclk = ~pclk;
    pwm_output_fault_sync DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .pwm_out(pwm_out), .irq(irq));
    pwm_load LOAD (.pclk(pclk), .clr(clr), .pins(pwm_out), .high_cnt(high_cnt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Ten ticks of pin highs; diff counts phase mismatch of pins 0 and 2
    task automatic meas;
        diff = 0;
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (10) begin
            @(posedge pclk);
            #1 diff += int'(pwm_out[0] !== pwm_out[2]);
        end
    endtask
    task automatic t_regs;
        apb(1'b0, OFS_PERIOD0, 32'h0);
        check(rdata, 32'h0000FFFF);
        apb(1'b1, OFS_WIDTH0, 32'h5);
        apb(1'b1, OFS_WIDTH0, 32'h3);
        apb(1'b0, OFS_WIDTH0, 32'h0);
        check(rdata, 32'h3);
        apb(1'b0, OFS_ACTIVE0, 32'h0);
        check(rdata, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        check(32'(rerr), 32'h1);
    endtask
    task automatic t_sync;
        apb(1'b1, OFS_PERIOD0, 32'h9);
        apb(1'b1, OFS_PERIOD0 + 12'h4, 32'h9);
        apb(1'b1, OFS_WIDTH0 + 12'h4, 32'h3);
        apb(1'b1, OFS_WIDTH0 + 12'h8, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h5);
        apb(1'b1, OFS_SYNC, 32'h30);
        apb(1'b1, OFS_SYNC, 32'h3);
        repeat (12) @(posedge pclk);
        apb(1'b0, OFS_ACTIVE0, 32'h0);
        check(rdata, 32'h3);
        meas;
        check(32'(high_cnt[0]), 32'h3);
        check(32'(high_cnt[1]), 32'h0);
        check(32'(diff), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h105);
        meas;
        check(32'(high_cnt[0]), 32'h7);
    endtask
    task automatic t_fault;
        apb(1'b1, OFS_CTRL, 32'h0D030107);
        @(posedge pclk);
        fault_in <= 4'h1;
        repeat (4) @(posedge pclk);
        meas;
        check(32'(high_cnt[0]), 32'hA);
        check(32'(high_cnt[1]), 32'h0);
        check(32'(high_cnt[2]), 32'h3);
        apb(1'b0, OFS_FAULT, 32'h0);
        check(rdata, 32'h1);
        @(posedge pclk);
        fault_in <= 4'h0;
    endtask
    task automatic t_irq;
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        check(rdata & 32'hF3, 32'h13);
        apb(1'b1, OFS_IRQ_EN, 32'h10);
        @(posedge pclk);
        #1 check(32'(irq), 32'h1);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        @(posedge pclk);
        #1 check(32'(irq), 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h10);
        apb(1'b1, OFS_IRQ_CLR, 32'h10);
        @(posedge pclk);
        #1 check(32'(irq), 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_sync;
        t_fault;
        t_irq;
        end_of_test;
    end
    // Run needs about 130 cycles; the 5000-cycle limit allows over thirty times that
    initial begin
        #250000;
        bad_count++;
        end_of_test;
    end
endmodule // pwm_output_fault_sync_tb_top
`default_nettype wire
